// file: src/ecwm_map.svh
// offsets, field positions, reset values of the config word mapper
`ifndef ECWM_MAP_SVH
`define ECWM_MAP_SVH
// eeprom word addresses
`define ECWM_W_GEN2 8'h10
`define ECWM_W_EMPH 8'h12
`define ECWM_W_PHY2 8'h14
`define ECWM_W_CSR4_LO 8'h16
`define ECWM_W_CSR4_HI 8'h18
`define ECWM_W_CSR5_LO 8'h1A
`define ECWM_W_CSR5_HI 8'h1C
`define ECWM_W_DELTA 8'h1E
`define ECWM_W_LINK0 8'h20
`define ECWM_LINK_PORTS 3
// per-port register offsets inside a port window
`define ECWM_R_INTPIN 8'h3C
`define ECWM_R_DESKEW 8'h68
`define ECWM_R_PHY1 8'h78
`define ECWM_R_PHY2 8'h7C
`define ECWM_R_CSR4 8'h84
`define ECWM_R_CSR5 8'h88
`define ECWM_R_TLCTRL 8'h8C
`define ECWM_R_PHY3 8'h90
`define ECWM_R_BUFCTRL 8'h98
// own control and status words in window 0
`define ECWM_A_CTRL 8'h00
`define ECWM_A_STATUS 8'h04
`define ECWM_PORTS 6
// field positions
`define ECWM_F_GEN2 31
`define ECWM_F_INTA 8
`define ECWM_F_ABORT 2
`define ECWM_F_GNTIDLE 7
`define ECWM_F_VCFLG 12
`define ECWM_F_SCRAM 8
`define ECWM_F_L0S 10
`define ECWM_F_SPDSEL 12
`define ECWM_F_SPDEN 14
`define ECWM_F_DESKEW 13
// hardware reset values of the per-port registers
`define ECWM_RST_INTPIN 32'h0000_0000
`define ECWM_RST_DESKEW 32'h0000_0000
`define ECWM_RST_PHY1 32'h0000_0000
`define ECWM_RST_PHY2 32'h0000_0000
`define ECWM_RST_CSR4 32'h0000_0000
`define ECWM_RST_CSR5 32'h0000_0000
`define ECWM_RST_TLCTRL 32'h0000_0000
`define ECWM_RST_PHY3 32'h0000_0000
`define ECWM_RST_BUFCTRL 32'h0000_0000
`endif

// file: src/ecwm_pkg.sv
// types of the config word mapper
package ecwm_pkg;
  typedef enum logic [1:0] {
    ECWM_IDLE,
    ECWM_LOAD,
    ECWM_DONE
  } ecwm_phase_t;

  typedef struct packed {
    logic [31:0] intpin;
    logic [31:0] deskew;
    logic [31:0] phy1;
    logic [31:0] phy2;
    logic [31:0] csr4;
    logic [31:0] csr5;
    logic [31:0] tlctrl;
    logic [31:0] phy3;
    logic [31:0] bufctrl;
  } ecwm_port_cfg_t;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [15:0] data;
  } ecwm_ee_word_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ecwm_apb_req_t;

  typedef struct packed {
    ecwm_phase_t phase;
    logic load_en;
    logic train_skip;
    logic [7:0] word_cnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic train_en;
    logic load_busy;
    ecwm_port_cfg_t [5:0] cfg;
  } ecwm_state_t;
endpackage : ecwm_pkg

// file: src/ecwm_mapper.sv
// eeprom config word mapper: loads words into per-port config registers
// Overview of operation
// [RQ1] bit 15 of word 10h goes to bit 31 of the 8Ch register of every port.
// [RQ2] word 12h bits 4:0, 9:5, 14:10 go to 78h bits 20:16, 25:21, 30:26.
// [RQ3] bit 15 of word 12h goes to 3Ch bit 8 of ports 1 to 5 only.
// [RQ4] word 14h bits 3:0, 6:4 go to 7Ch 3:0, 6:4 and bits 11:7 to 90h 19:15.
// [RQ5] word 14h bits 12, 13, 14 go to 8Ch bits 2, 7 and 12.
// [RQ6] words 16h and 18h fill 84h bits 15:0 and 31:16.
// [RQ7] word 1Ah fills 88h bits 15:0 and word 1Ch bits 7:0 fill 88h 23:16.
// [RQ8] word 1Ch bits 15:8 go to 98h bits 23:16.
// [RQ9] word 1Eh bits 11:0 go as six two-bit deltas to 90h bits 31:20.
// [RQ10] word 1Eh bits 15:12 go to 8Ch bits 29:26.
// [RQ11] words 20h, 22h, 24h bits 7:0 go to 78h bits 7:0 of ports 0, 1, 2.
// [RQ12] link word bits 9:8 go to 68h bits 14:13 of that port.
// [RQ13] link word bits 11:10 go to 78h 9:8 and bit 12 to 78h bit 10.
// [RQ14] link word bits 14:13 go to 78h 13:12 and bit 15 to 78h bit 14.
// [RQ15] link training waits for the load to end; unmapped bits keep reset.
`include "ecwm_map.svh"

module ecwm_mapper
  import ecwm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic load_start,
  input wire logic load_end,
  input wire ecwm_ee_word_t ee_word,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic train_en,
  output logic load_busy,
  output ecwm_port_cfg_t [5:0] port_cfg
);

  ecwm_state_t st;
  ecwm_state_t next_st;
  ecwm_apb_req_t req;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                 paddr: paddr, pwdata: pwdata};

  // reset image: every field at its hardware reset value
  function automatic ecwm_state_t reset_state();
    ecwm_state_t s;
    s = '0;
    s.phase = ECWM_IDLE;
    s.load_en = 1'b1;
    for (int p = 0; p < `ECWM_PORTS; p++) begin
      s.cfg[p].intpin = `ECWM_RST_INTPIN;
      s.cfg[p].deskew = `ECWM_RST_DESKEW;
      s.cfg[p].phy1 = `ECWM_RST_PHY1;
      s.cfg[p].phy2 = `ECWM_RST_PHY2;
      s.cfg[p].csr4 = `ECWM_RST_CSR4;
      s.cfg[p].csr5 = `ECWM_RST_CSR5;
      s.cfg[p].tlctrl = `ECWM_RST_TLCTRL;
      s.cfg[p].phy3 = `ECWM_RST_PHY3;
      s.cfg[p].bufctrl = `ECWM_RST_BUFCTRL;
    end
    return s;
  endfunction : reset_state

  // address decode shared by read and write: {hit, data}
  function automatic logic [32:0] reg_decode(
    input ecwm_state_t s,
    input logic [11:0] a
  );
    logic [32:0] r;
    logic [2:0] idx;
    r = '0;
    idx = 3'(a[10:8] - 3'h1);
    if (a[11] || a[1:0] != 2'b00) begin
      r = '0;
    end else if (a[10:8] == 3'h0) begin
      if (a[7:0] == `ECWM_A_CTRL) begin
        r = {1'b1, 30'h0, s.train_skip, s.load_en};
      end else if (a[7:0] == `ECWM_A_STATUS) begin
        r = {1'b1, 16'h0, s.word_cnt, 4'h0, s.train_en,
             s.phase == ECWM_DONE, s.phase == ECWM_LOAD, 1'b0};
      end
    end else if (a[10:8] <= 3'(`ECWM_PORTS)) begin
      unique case (a[7:0])
        `ECWM_R_INTPIN: r = {1'b1, s.cfg[idx].intpin};
        `ECWM_R_DESKEW: r = {1'b1, s.cfg[idx].deskew};
        `ECWM_R_PHY1: r = {1'b1, s.cfg[idx].phy1};
        `ECWM_R_PHY2: r = {1'b1, s.cfg[idx].phy2};
        `ECWM_R_CSR4: r = {1'b1, s.cfg[idx].csr4};
        `ECWM_R_CSR5: r = {1'b1, s.cfg[idx].csr5};
        `ECWM_R_TLCTRL: r = {1'b1, s.cfg[idx].tlctrl};
        `ECWM_R_PHY3: r = {1'b1, s.cfg[idx].phy3};
        `ECWM_R_BUFCTRL: r = {1'b1, s.cfg[idx].bufctrl};
        default: r = '0;
      endcase
    end
    return r;
  endfunction : reg_decode

  // copies one eeprom word into the fields of one port
  function automatic ecwm_port_cfg_t map_word(
    input ecwm_port_cfg_t c,
    input int p,
    input logic [7:0] a,
    input logic [15:0] d
  );
    ecwm_port_cfg_t n;
    n = c;
    if (a == `ECWM_W_GEN2) begin
      n.tlctrl[`ECWM_F_GEN2] = d[15]; // RQ1
    end
    if (a == `ECWM_W_EMPH) begin
      n.phy1[30:16] = d[14:0]; // RQ2
      if (p != 0) begin
        n.intpin[`ECWM_F_INTA] = d[15]; // RQ3
      end
    end
    if (a == `ECWM_W_PHY2) begin
      n.phy2[6:0] = d[6:0]; // RQ4
      n.phy3[19:15] = d[11:7]; // RQ4
      n.tlctrl[`ECWM_F_ABORT] = d[12]; // RQ5
      n.tlctrl[`ECWM_F_GNTIDLE] = d[13]; // RQ5
      n.tlctrl[`ECWM_F_VCFLG] = d[14]; // RQ5
    end
    if (a == `ECWM_W_CSR4_LO) begin
      n.csr4[15:0] = d; // RQ6
    end
    if (a == `ECWM_W_CSR4_HI) begin
      n.csr4[31:16] = d; // RQ6
    end
    if (a == `ECWM_W_CSR5_LO) begin
      n.csr5[15:0] = d; // RQ7
    end
    if (a == `ECWM_W_CSR5_HI) begin
      n.csr5[23:16] = d[7:0]; // RQ7
      n.bufctrl[23:16] = d[15:8]; // RQ8
    end
    if (a == `ECWM_W_DELTA) begin
      n.phy3[31:20] = d[11:0]; // RQ9
      n.tlctrl[29:26] = d[15:12]; // RQ10
    end
    // ports 3 to 5 have no link word, so only ports 0 to 2 match
    if (p < `ECWM_LINK_PORTS && a == 8'(`ECWM_W_LINK0 + 2 * p)) begin
      n.phy1[7:0] = d[7:0]; // RQ11
      n.deskew[14:13] = d[9:8]; // RQ12
      n.phy1[`ECWM_F_SCRAM +: 2] = d[11:10]; // RQ13
      n.phy1[`ECWM_F_L0S] = d[12]; // RQ13
      n.phy1[`ECWM_F_SPDSEL +: 2] = d[14:13]; // RQ14
      n.phy1[`ECWM_F_SPDEN] = d[15]; // RQ14
    end
    return n;
  endfunction : map_word

  always_comb begin
    logic [32:0] dec;
    dec = reg_decode(st, req.paddr);
    next_st = st;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    // one wait state: answer in the second access cycle
    if (req.psel && req.penable && !st.pready) begin
      next_st.pready = 1'b1;
      next_st.pslverr = !dec[32];
      next_st.prdata = req.pwrite ? 32'h0000_0000 : dec[31:0];
    end
    // write lands on the edge that samples pready high
    if (req.psel && req.penable && st.pready && req.pwrite && dec[32] &&
        req.paddr[10:0] == {3'h0, `ECWM_A_CTRL}) begin
      next_st.load_en = req.pwdata[0];
      next_st.train_skip = req.pwdata[1];
    end
    unique case (st.phase)
      ECWM_IDLE: begin
        if (load_start) begin
          next_st.phase = ECWM_LOAD;
          next_st.word_cnt = 8'h00;
        end
      end
      ECWM_LOAD: begin
        // words outside a load are dropped so a stray strobe cannot corrupt
        if (ee_word.valid && st.load_en) begin
          for (int p = 0; p < `ECWM_PORTS; p++) begin
            next_st.cfg[p] = map_word(st.cfg[p], p, ee_word.addr,
                                      ee_word.data);
          end
          next_st.word_cnt = 8'(st.word_cnt + 8'h01);
        end
        if (load_end) begin
          next_st.phase = ECWM_DONE;
        end
      end
      ECWM_DONE: begin
        if (load_start) begin
          next_st.phase = ECWM_LOAD;
          next_st.word_cnt = 8'h00;
        end
      end
    endcase
    // training held off while a load is open; a last word in the end
    // cycle is stored on the same edge on which train_en rises
    next_st.train_en = (next_st.phase == ECWM_DONE) ||
                       (next_st.train_skip && next_st.phase != ECWM_LOAD); // RQ15
    // busy comes from its own flop so the output carries no decode glitch
    next_st.load_busy = next_st.phase == ECWM_LOAD;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st <= reset_state(); // RQ15
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign train_en = st.train_en;
  assign load_busy = st.load_busy;
  assign port_cfg = st.cfg;

endmodule : ecwm_mapper

// file: verification/ecwm_monitor.sv
// port checker of the config word mapper
module ecwm_monitor
  import ecwm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic load_start,
  input wire logic load_end,
  input wire ecwm_ee_word_t ee_word,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic train_en,
  input wire logic load_busy,
  input wire ecwm_port_cfg_t [5:0] port_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] d_q;
  always_ff @(posedge ref_clk) d_q <= ee_word.data;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_word(logic [7:0] a);
    ee_word.valid && ee_word.addr == a && load_busy;
  endsequence
  chk_cfg_hold: assert property (!(ee_word.valid && load_busy)
    |=> $stable(port_cfg)) else $error("cfg moved");
  chk_train_gate: assert property (load_busy && load_end
    |=> train_en) else $error("no train");
  chk_load_open: assert property (load_start && !load_busy
    |=> load_busy && !train_en) else $error("load not opened");
  for (genvar p = 0; p < 6; p++) begin : g_port
    ecwm_port_cfg_t c;
    assign c = port_cfg[p];
    chk_gen2_bit: assert property (s_word(8'h10)
      |=> c.tlctrl[31] == d_q[15]) else $error("gen2");
    chk_emph_nominal: assert property (s_word(8'h12)
      |=> c.phy1[30:16] == d_q[14:0]) else $error("emph");
    chk_int_pin: assert property (s_word(8'h12)
      |=> c.intpin[8] == (p > 0 && d_q[15])) else $error("intpin");
    chk_phy_latency: assert property (s_word(8'h14)
      |=> {c.phy3[19:15], c.phy2[6:0]} == d_q[11:0]) else $error("lat");
    chk_arb_bits: assert property (s_word(8'h14)
      |=> {c.tlctrl[12], c.tlctrl[7], c.tlctrl[2]} == $past(ee_word.data[14:12]))
      else $error("arb");
    chk_buf_csr5: assert property (s_word(8'h1C)
      |=> {c.bufctrl[23:16], c.csr5[23:16]} == d_q) else $error("buf");
    chk_delta_mac: assert property (s_word(8'h1E)
      |=> {c.tlctrl[29:26], c.phy3[31:20]} == d_q) else $error("delta");
    if (p < 3) begin : g_link
      chk_link_word: assert property (s_word(8'(32 + 2 * p))
        |=> {c.phy1[14:12], c.phy1[10:0], c.deskew[14:13]}
        == {d_q[15:10], d_q[7:0], d_q[9:8]}) else $error("link");
    end
  end
endmodule : ecwm_monitor

bind ecwm_mapper ecwm_monitor u_mon (.*);

// file: verification/ecwm_ee_model.sv
// eeprom side model: streams configuration words into the mapper
module ecwm_ee_model
  import ecwm_pkg::*;
(
  output logic load_start,
  output logic load_end,
  output ecwm_ee_word_t ee_word,
  input wire logic ref_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:10];
  initial begin
    load_start = 0;
    load_end = 0;
    ee_word = '0;
  end
  // idle cycles show inverted data so a stale word never passes as fresh
  task automatic send(input bit frame, input int gap);
    @(posedge ref_clk);
    load_start <= frame;
    @(posedge ref_clk);
    load_start <= 0;
    for (int i = 0; i < 11; i++) begin
      ee_word <= '{1'b1, 8'(16 + 2 * i), mem[i]};
      repeat (gap) begin
        @(posedge ref_clk);
        ee_word <= '{1'b0, 8'(~(16 + 2 * i)), ~mem[i]};
      end
      @(posedge ref_clk);
    end
    ee_word <= '{1'b0, 8'hFF, ~mem[10]};
    load_end <= frame;
    @(posedge ref_clk);
    load_end <= 0;
  endtask : send
endmodule : ecwm_ee_model

// file: verification/tb_top.sv
// self-checking bench of the config word mapper
module tb_top;
  import ecwm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, train_en, load_busy, load_start, load_end, err;
  ecwm_ee_word_t ee_word;
  ecwm_port_cfg_t [5:0] port_cfg, snap;
  ecwm_port_cfg_t c, e;
  int miscompares = 0;
  int num_checks = 0;
  always #2.5 ref_clk = ~ref_clk;
  ecwm_mapper DUT (.*);
  ecwm_ee_model EE (.*);
  function automatic ecwm_port_cfg_t exp_cfg(int p);
    ecwm_port_cfg_t x;
    logic [15:0] m [0:10];
    m = EE.mem;
    x = '0;
    x.tlctrl[31] = m[0][15];
    x.phy1[30:16] = m[1][14:0];
    x.intpin[8] = (p > 0) & m[1][15];
    {x.phy3[19:15], x.phy2[6:0]} = m[2][11:0];
    {x.tlctrl[12], x.tlctrl[7], x.tlctrl[2]} = m[2][14:12];
    x.csr4 = {m[4], m[3]};
    x.csr5[23:0] = {m[6][7:0], m[5]};
    x.bufctrl[23:16] = m[6][15:8];
    {x.tlctrl[29:26], x.phy3[31:20]} = m[7];
    if (p < 3) begin
      {x.phy1[14:12], x.phy1[10:0]} = {m[8+p][15:10], m[8+p][7:0]};
      x.deskew[14:13] = m[8+p][9:8];
    end
    return x;
  endfunction : exp_cfg
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic check(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      miscompares++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : check
  task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      check(0, "apb hang");
    if (pready !== 1'b1)
      end_of_test();
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  initial begin
    void'($urandom(32'h9D01BDB2));
    repeat (20) @(posedge ref_clk);
    rst_n <= 1;
    check(port_cfg === '0 && train_en === 1'b0, "reset");
    check(load_busy === 1'b0 && pready === 1'b0, "reset busy");
    apb(1, 12'h000, 32'h1);
    for (int r = 0; r < 3; r++) begin
      foreach (EE.mem[i]) EE.mem[i] = (r == 0) ? 16'hFFFF : 16'($urandom);
      EE.send(1, r);
      @(posedge ref_clk);
      check(train_en === 1'b1, "train");
      check(load_busy === 1'b0, "busy after load");
      for (int p = 0; p < 6; p++) begin
        c = port_cfg[p];
        e = exp_cfg(p);
        check(c.deskew === e.deskew, "deskew");
        check(c.phy1 === e.phy1, "phy1");
        check(c === e, "map");
        apb(0, 12'(256 * p + 12'h18C), 0);
        check(rd === e.tlctrl && err === 1'b0, "read");
      end
      $display("load test %0d done", r);
    end
    apb(1, 12'h18C, '1);
    check(port_cfg[0] === exp_cfg(0) && err === 1'b0, "read only");
    apb(0, 12'hFFC, 0);
    check(err === 1'b1, "unmapped");
    apb(0, 12'h004, 0);
    check(rd[3:1] === 3'b110 && rd[15:8] === 8'h0B, "status");
    $display("register test done");
    snap = port_cfg;
    foreach (EE.mem[i]) EE.mem[i] = 16'($urandom);
    EE.send(0, 0);
    check(port_cfg === snap, "refused");
    $display("refusal test done");
    end_of_test();
  end
endmodule : tb_top
